// File: logic/ofpif_pkg.sv
/*
 ofpif_pkg: shared constants and types for the ofdm input port link,
 sender end and receiver end.
 assumes: both ends and the interface import this package whole.
*/
`default_nettype none

package ofpif_pkg;

    // link geometry
    localparam int LINES    = 9;
    localparam int CHANS    = 3;
    localparam int GRP      = 3;
    localparam int BEATS    = 4;
    localparam int SAMP_W   = 6;
    localparam int IDX_W    = 4;
    localparam int WIDE_W   = 18;
    localparam int DATA_W   = 36;
    localparam int SYNC_W   = 12;
    localparam int WORD_W   = 48;
    localparam int SYNC_RUN = 8;

    // documented rates, kept for reference of the real link
    localparam real LINE_RATE_MBPS   = 819.2;
    localparam real SAMPLE_RATE_MSPS = 204.8;

    // symbol period (transform size plus prefix) in samples, plain default
    localparam int SYMBOL_SAMPLES_DEF = 4352;

    // clock_in cycles per half period of the forwarded clock (80 ns link)
    localparam int LINK_HALF_DEF = 8;

    // beat history at the end of a boundary: one low, eight high
    localparam logic [8:0] BOUNDARY_PAT = 9'h0ff;

    // bit-loading index that marks a pilot subcarrier
    localparam logic [3:0] PILOT_INDEX = 4'h8;

    // pilot levels and pilot sequence generator seed
    localparam logic [5:0]  PILOT_POS = 6'h1f;
    localparam logic [5:0]  PILOT_NEG = 6'h21;
    localparam logic [10:0] LFSR_SEED = 11'h7ff;

    // reset values
    localparam logic [1:0] BUF_CNT_RST = 2'h0;
    localparam logic       READY_RST   = 1'b1;

    typedef enum logic [1:0] {
        OFPIF_HUNT,
        OFPIF_LOCK,
        OFPIF_MUTE
    } ofpif_state_t;

endpackage

`default_nettype wire

// File: logic/ofpif_link_if.sv
/*
 ofpif_link_if: the pins of one ofdm input port, forwarded clock,
 nine data lines and three frame-sync lines.
 assumes: one sender and one receiver joined by the testbench.
*/
`timescale 1ns/10ps
`default_nettype none

interface ofpif_link_if
    import ofpif_pkg::*;
    ;
    logic              forwarded_port_clock;
    logic [LINES-1:0]  port_data_pair;
    logic [CHANS-1:0]  channel_frame_sync_pair;

    modport sender (
        output forwarded_port_clock,
        output port_data_pair,
        output channel_frame_sync_pair
    );

    modport receiver (
        input  forwarded_port_clock,
        input  port_data_pair,
        input  channel_frame_sync_pair
    );

endinterface

`default_nettype wire

// File: logic/ofpif_sender.sv
/*
 ofpif_sender: upstream end of one ofdm input port. takes one word per
 sample (data for three channels or one wide sample, plus the sync beats)
 through a two-entry buffer and serialises it over four ddr beats.
 assumes: user supplies already-mapped samples and the sync pattern
 (prefix high run, bit-loading beats); clock_in is the only clock.
*/
`timescale 1ns/10ps
`default_nettype none

module ofpif_sender
    import ofpif_pkg::*;
#(
    parameter int LINK_HALF = LINK_HALF_DEF
) (
    input  wire logic              clock_in,
    input  wire logic              reset_in,
    input  wire logic              bypass_in,
    input  wire logic              word_valid_in,
    input  wire logic [DATA_W-1:0] word_data_in,
    input  wire logic [SYNC_W-1:0] word_sync_in,
    output logic                   word_ready_out,
    output logic                   underrun_out,
    ofpif_link_if.sender           link
);

    typedef struct packed {
        logic [7:0]                   div;
        logic [1:0]                   beat;
        logic                         clk;
        logic [LINES-1:0]             data;
        logic [CHANS-1:0]             sync;
        logic [WORD_W-1:0]            cur;
        logic [1:0][WORD_W-1:0]       buffer;
        logic [1:0]                   cnt;
        logic                         ready;
        logic                         underrun;
    } ofpif_tx_t;

    localparam logic [7:0] DIV_LAST = 8'(LINK_HALF - 1);
    localparam logic [7:0] DIV_MID  = 8'(LINK_HALF / 2);

    ofpif_tx_t q;
    ofpif_tx_t n;

    // divider, beat sequencing, buffer and line drive
    always_comb begin
        logic              push;
        logic              pop;
        logic [1:0]        wr;
        logic [WORD_W-1:0] w;
        int                b;
        n    = q;
        push = word_valid_in && q.ready;
        pop  = 1'b0;
        wr   = 2'h0;
        w    = q.cur;
        b    = int'(q.beat);
        n.underrun = 1'b0;
        n.div = (q.div == DIV_LAST) ? 8'h00 : q.div + 8'h01;
        // forwarded clock from a divider, data moved a quarter later
        if (q.div == 8'h00) begin
            n.clk = ~q.clk;
        end
        if (q.div == DIV_MID) begin
            n.beat = q.beat + 2'h1;
            if (q.beat == 2'h0) begin
                pop        = (q.cnt != 2'h0);
                w          = pop ? q.buffer[0] : '0;
                n.underrun = !pop; // empty slot goes out as a muted sample (R11)
                n.cur      = w;
            end
            if (bypass_in) begin
                n.data = w[DATA_W-1-LINES*b -: LINES]; // R4
                n.sync = {2'b00, w[DATA_W+3-b]}; // R18
            end else begin
                for (int c = 0; c < CHANS; c++) begin
                    // mapped samples pass untouched, msb beat first (R19)
                    n.data[GRP*c +: GRP] = w[12*c+11-GRP*b -: GRP]; // R6 R7 R8
                    n.sync[c] = w[DATA_W+4*c+3-b]; // R10 R17
                end
            end
        end
        // two-entry buffer; ready drops when both entries hold words
        if (pop) begin
            n.buffer[0] = q.buffer[1];
        end
        wr = q.cnt - {1'b0, pop};
        if (push) begin
            n.buffer[wr[0]] = {word_sync_in, word_data_in};
        end
        n.cnt   = q.cnt + {1'b0, push} - {1'b0, pop};
        n.ready = (n.cnt < 2'h2);
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            q       <= '0;
            q.cnt   <= BUF_CNT_RST;
            q.ready <= READY_RST;
        end else begin
            q <= n;
        end
    end

    // every output straight from the state register (R1)
    assign link.forwarded_port_clock    = q.clk;
    assign link.port_data_pair          = q.data;
    assign link.channel_frame_sync_pair = q.sync;
    assign word_ready_out               = q.ready;
    assign underrun_out                 = q.underrun;

endmodule

`default_nettype wire

// File: logic/ofpif_receiver.sv
/*
 ofpif_receiver: device end of one ofdm input port. samples the
 forwarded clock, data and sync lines on clock_in, finds both clock
 edges, deserialises three channels of 6-bit i/q (or one 18-bit wide
 stream in bypass) and tracks symbol boundaries per channel.
 assumes: forwarded clock well below clock_in/4 so each half period
 spans several clock_in cycles; mute_in and bypass_in are synchronous
 configuration levels on clock_in.
*/
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// (R1) nine ddr lines, forwarded clock, three syncs
// (R2) fixed channel sample rate only
// (R3) three channels of 6-bit i/q out
// (R4) bypass gives one 18-bit i/q stream
// (R5) bypass: one wide block, no channels
// (R6) sender drives sync and three lines
// (R7) beats: i high, i low, q high, q low
// (R8) lines 2..0, 5..3, 8..6 per channel
// (R9) sync marks boundary and carries index
// (R10) sender holds sync high ending prefix
// (R11) mute bit or sync low disables
// (R12) boundary starts symbol processing
// (R13) sync held low mutes the channel
// (R14) boundary recurs each symbol period
// (R15) missing boundary mutes until next one
// (R16) reconfigure only while muted, resync after
// (R17) sync pair c pairs with group c
// (R18) bypass uses first sync for all
// (R19) sender maps constellations upstream
// (R20) boundary: rise, eight high beats, then subcarrier
// (R21) index eight replaced by pilot values
// (R22) both clock edges, 12-bit word, index
// (R23) each channel tracks sync independently
module ofpif_receiver
    import ofpif_pkg::*;
#(
    parameter int SYMBOL_SAMPLES = SYMBOL_SAMPLES_DEF
) (
    input  wire logic                          clock_in,
    input  wire logic                          reset_in,
    input  wire logic                          bypass_in,
    input  wire logic [CHANS-1:0]              mute_in,
    ofpif_link_if.receiver                     link,
    output logic [CHANS-1:0]                   sample_valid_out,
    output logic [CHANS-1:0][SAMP_W-1:0]       sample_i_out,
    output logic [CHANS-1:0][SAMP_W-1:0]       sample_q_out,
    output logic [CHANS-1:0][IDX_W-1:0]        sample_index_out,
    output logic [CHANS-1:0]                   symbol_start_out,
    output logic [CHANS-1:0]                   pilot_out,
    output logic [CHANS-1:0]                   locked_out,
    output logic                               wide_valid_out,
    output logic [WIDE_W-1:0]                  wide_i_out,
    output logic [WIDE_W-1:0]                  wide_q_out
);

    // pin vector: clock on top, then syncs, then data lines
    localparam int PIN_W = 1 + CHANS + LINES;
    localparam int CLK_B = PIN_W - 1;

    // last beat of a symbol period, counted from the boundary beat
    localparam logic [15:0] LAST_BEAT = 16'(SYMBOL_SAMPLES * BEATS - 1);

    typedef struct packed {
        logic [PIN_W-1:0]                 pin_s1;
        logic [PIN_W-1:0]                 pin_s2;
        logic                             clk_prev;
        ofpif_state_t [CHANS-1:0]         st;
        logic [CHANS-1:0][15:0]           cnt;
        logic [CHANS-1:0][8:0]            hist;
        logic [CHANS-1:0][8:0]            dsh;
        logic [CHANS-1:0][2:0]            ish;
        logic [CHANS-1:0][10:0]           lfsr;
        logic [26:0]                      wsh;
        logic [CHANS-1:0]                 valid;
        logic [CHANS-1:0][SAMP_W-1:0]     si;
        logic [CHANS-1:0][SAMP_W-1:0]     sq;
        logic [CHANS-1:0][IDX_W-1:0]      idx;
        logic [CHANS-1:0]                 start;
        logic [CHANS-1:0]                 pilot;
        logic [CHANS-1:0]                 locked;
        logic                             wvalid;
        logic [WIDE_W-1:0]                wi;
        logic [WIDE_W-1:0]                wq;
    } ofpif_rx_t;

    ofpif_rx_t q;
    ofpif_rx_t n;

    // synchroniser, edge finder, per-channel framing and assembly
    always_comb begin
        logic [8:0]      h;
        logic [2:0]      d3;
        logic            s;
        logic            pat;
        logic            last;
        logic            edge_seen;
        logic [11:0]     w;
        logic [3:0]      ix;
        n         = q;
        h         = 9'h000;
        d3        = 3'h0;
        s         = 1'b0;
        pat       = 1'b0;
        last      = 1'b0;
        edge_seen = 1'b0;
        w         = 12'h000;
        ix        = 4'h0;
        // two flops on every pin before anything looks at it
        n.pin_s1   = {link.forwarded_port_clock,
                      link.channel_frame_sync_pair,
                      link.port_data_pair}; // R1
        n.pin_s2   = q.pin_s1;
        n.clk_prev = q.pin_s2[CLK_B];
        edge_seen  = (q.pin_s2[CLK_B] != q.clk_prev); // R22
        // output strobes are one-cycle pulses
        n.valid  = '0;
        n.start  = '0;
        n.pilot  = '0;
        n.wvalid = 1'b0;
        if (edge_seen) begin
            // sender moves data a quarter period after each edge, so the
            // edge itself falls mid-eye and no extra delay is needed
            for (int c = 0; c < CHANS; c++) begin // R23
                d3   = q.pin_s2[GRP*c +: GRP]; // R8
                s    = q.pin_s2[LINES+c]; // R17
                h    = {q.hist[c][7:0], s};
                pat  = (h == BOUNDARY_PAT); // R20
                last = (q.cnt[c] == LAST_BEAT);
                w    = {q.dsh[c], d3}; // R7
                ix   = {q.ish[c], s}; // R9
                n.hist[c] = h;
                n.dsh[c]  = {q.dsh[c][5:0], d3};
                n.ish[c]  = {q.ish[c][1:0], s};
                n.cnt[c]  = last ? 16'h0000 : q.cnt[c] + 16'h0001;
                case (q.st[c])
                    OFPIF_HUNT: begin
                        n.cnt[c] = 16'h0000;
                        if (pat) begin
                            n.st[c] = OFPIF_LOCK; // R20
                        end
                    end
                    OFPIF_LOCK: begin
                        // boundary only checked where it is expected
                        if (last && !pat) begin
                            n.st[c] = OFPIF_MUTE; // R14 R15
                        end
                    end
                    OFPIF_MUTE: begin
                        // a fresh boundary anywhere restarts the channel
                        if (pat) begin
                            n.st[c]  = OFPIF_LOCK; // R16
                            n.cnt[c] = 16'h0000;
                        end
                    end
                    default: begin
                        n.st[c] = OFPIF_HUNT;
                    end
                endcase
                // fourth beat completes a sample; hunting channels stay silent
                if (q.st[c] != OFPIF_HUNT && q.cnt[c][1:0] == 2'h3) begin // R13
                    n.lfsr[c] = {q.lfsr[c][9:0], q.lfsr[c][10] ^ q.lfsr[c][8]};
                    if (!bypass_in) begin // R5
                        n.valid[c] = 1'b1; // R3
                        n.start[c] = (q.cnt[c] == 16'h0003); // R12
                        n.idx[c]   = ix; // R22
                        if (q.st[c] == OFPIF_MUTE || mute_in[c]) begin
                            n.si[c]  = '0; // R11 R15
                            n.sq[c]  = '0;
                            n.idx[c] = '0;
                        end else if (ix == PILOT_INDEX) begin
                            // bpsk pilot from the channel's own sequence
                            n.pilot[c] = 1'b1; // R21
                            n.si[c]    = q.lfsr[c][0] ? PILOT_NEG : PILOT_POS;
                            n.sq[c]    = '0;
                        end else begin
                            n.si[c] = w[11:6]; // R3
                            n.sq[c] = w[5:0];
                        end
                    end
                end
            end
            // wide path rides on the first channel's framing
            n.wsh = {q.wsh[17:0], q.pin_s2[LINES-1:0]};
            if (bypass_in && q.st[0] != OFPIF_HUNT && q.cnt[0][1:0] == 2'h3) begin // R18
                n.wvalid = 1'b1; // R4
                if (q.st[0] == OFPIF_MUTE) begin
                    n.wi = '0; // R15
                    n.wq = '0;
                end else begin
                    n.wi = q.wsh[26:9];
                    n.wq = {q.wsh[8:0], q.pin_s2[LINES-1:0]};
                end
            end
        end
        // lock status mirrors the state after this cycle's update
        for (int c = 0; c < CHANS; c++) begin
            n.locked[c] = (n.st[c] == OFPIF_LOCK);
        end
    end

    // the sample rate is fixed; no rate selection exists (R2)
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            q      <= '0;
            q.lfsr <= {CHANS{LFSR_SEED}};
        end else begin
            q <= n;
        end
    end

    // outputs straight from the state register
    assign sample_valid_out = q.valid;
    assign sample_i_out     = q.si;
    assign sample_q_out     = q.sq;
    assign sample_index_out = q.idx;
    assign symbol_start_out = q.start;
    assign pilot_out        = q.pilot;
    assign locked_out       = q.locked;
    assign wide_valid_out   = q.wvalid;
    assign wide_i_out       = q.wi;
    assign wide_q_out       = q.wq;

endmodule

`default_nettype wire

// File: verification/ofpif_link_asserts.sv
/*
 ofpif_link_asserts: timing checks on the pins of one ofdm input port.
 assumes: instantiated beside the link interface; LINK_HALF matches the sender.
*/
`timescale 1ns/10ps
`default_nettype none

module ofpif_link_asserts
    import ofpif_pkg::*;
#(
    parameter int LINK_HALF = LINK_HALF_DEF
) (
    input  wire logic             clock_in,
    input  wire logic             reset_in,
    input  wire logic             bypass_in,
    input  wire logic             underrun_out,
    input  wire logic             forwarded_port_clock,
    input  wire logic [LINES-1:0] port_data_pair,
    input  wire logic [CHANS-1:0] channel_frame_sync_pair
);
    localparam int REST    = LINK_HALF - LINK_HALF / 2;
    localparam int UR_WAIT = 16;

    logic       clk_q;
    logic       seen_q;
    logic [7:0] since_q;
    logic       clk_moved;

    assign clk_moved = forwarded_port_clock != clk_q;

    // cycles since the last link clock toggle; no clock, data or sync timing check before the first one
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            clk_q   <= 1'b0;
            seen_q  <= 1'b0;
            since_q <= 8'h00;
        end else begin
            clk_q   <= forwarded_port_clock;
            seen_q  <= seen_q | clk_moved;
            since_q <= clk_moved ? 8'h00 : since_q + 8'h01;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    a_clock_half_period: assert property (clk_moved && seen_q |-> since_q == LINK_HALF - 1)
        else $error("link clock half period has the wrong length");
    a_clock_keeps_running: assert property (seen_q |-> since_q < LINK_HALF)
        else $error("link clock stopped toggling");
    a_data_mid_half: assert property (seen_q && $changed(port_data_pair) |-> since_q == LINK_HALF / 2 - 1)
        else $error("data lines changed away from mid half period");
    a_sync_mid_half: assert property (seen_q && $changed(channel_frame_sync_pair) |-> since_q == LINK_HALF / 2 - 1)
        else $error("sync lines changed away from mid half period");
    a_clock_after_data: assert property (seen_q && $changed(port_data_pair) |-> ##REST clk_moved)
        else $error("link clock edge not centred after a data change");
    a_reset_link_idle: assert property (disable iff (1'b0) $fell(reset_in) |-> !forwarded_port_clock && port_data_pair == '0 && channel_frame_sync_pair == '0)
        else $error("link not idle when reset ends");
    a_bypass_sync_quiet: assert property (bypass_in |-> channel_frame_sync_pair[2:1] == 2'b00)
        else $error("spare sync lines driven in wide mode");
    a_underrun_zeros: assert property ($rose(underrun_out) |-> ##[0:UR_WAIT] (port_data_pair == '0 && channel_frame_sync_pair == '0))
        else $error("empty slot did not send zeros with sync low");
endmodule

`default_nettype wire

// File: verification/tb_top.sv
/*
 tb_top: drives the sender end, scores the receiver end of one ofdm port.
 assumes: receiver built with an eight-sample symbol period.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import ofpif_pkg::*;
    ;
    localparam int SYM = 8;
    logic                         clock_in, reset_in, bypass_in, word_valid_in, watching;
    logic [DATA_W-1:0]            word_data_in;
    logic [SYNC_W-1:0]            word_sync_in;
    logic [CHANS-1:0]             mute_in, sample_valid_out, symbol_start_out, pilot_out, locked_out;
    logic                         word_ready_out, underrun_out, wide_valid_out;
    logic [CHANS-1:0][SAMP_W-1:0] sample_i_out, sample_q_out;
    logic [CHANS-1:0][IDX_W-1:0]  sample_index_out;
    logic [WIDE_W-1:0]            wide_i_out, wide_q_out;
    logic [19:0]                  expq [CHANS][$];
    logic [35:0]                  wq [$];
    logic [19:0]                  e;
    logic [17:0]                  got;
    logic [31:0]                  seed;
    int                           failures, checks_done;

    ofpif_link_if ofpif_link_if_inst ();
    ofpif_sender #(.LINK_HALF(LINK_HALF_DEF)) ofpif_sender_inst (.clock_in(clock_in),
        .reset_in(reset_in), .bypass_in(bypass_in), .word_valid_in(word_valid_in),
        .word_data_in(word_data_in), .word_sync_in(word_sync_in),
        .word_ready_out(word_ready_out), .underrun_out(underrun_out), .link(ofpif_link_if_inst));
    ofpif_receiver #(.SYMBOL_SAMPLES(SYM)) ofpif_receiver_inst (.clock_in(clock_in),
        .reset_in(reset_in), .bypass_in(bypass_in), .mute_in(mute_in), .link(ofpif_link_if_inst),
        .sample_valid_out(sample_valid_out), .sample_i_out(sample_i_out),
        .sample_q_out(sample_q_out), .sample_index_out(sample_index_out),
        .symbol_start_out(symbol_start_out), .pilot_out(pilot_out), .locked_out(locked_out),
        .wide_valid_out(wide_valid_out), .wide_i_out(wide_i_out), .wide_q_out(wide_q_out));
    ofpif_link_asserts #(.LINK_HALF(LINK_HALF_DEF)) ofpif_link_asserts_inst (
        .clock_in(clock_in), .reset_in(reset_in), .bypass_in(bypass_in),
        .underrun_out(underrun_out),
        .forwarded_port_clock(ofpif_link_if_inst.forwarded_port_clock),
        .port_data_pair(ofpif_link_if_inst.port_data_pair),
        .channel_frame_sync_pair(ofpif_link_if_inst.channel_frame_sync_pair));

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // entered at a falling edge; holds the word until the sender takes it
    // ready is read mid-cycle, where it is settled, so the next rising
    // edge is the one that takes the word and no word goes in twice
    task automatic send_word(input logic [DATA_W-1:0] d, input logic [SYNC_W-1:0] s);
        word_data_in = d;
        word_sync_in = s;
        word_valid_in = 1'b1;
        while (word_ready_out !== 1'b1) @(negedge clock_in);
        @(posedge clock_in);
        @(negedge clock_in);
    endtask

    // one symbol period; kind 0 normal, 1 zeros, 2 not scored
    task automatic send_period(input logic [2:0] keep, input logic [2:0] zero,
                               input logic [2:0] dc, input logic [2:0] dct, input logic on);
        logic [DATA_W-1:0] d;
        logic [SYNC_W-1:0] s;
        logic [3:0]        idx;
        logic [1:0]        kind;
        for (int n = 0; n < SYM; n++) begin
            for (int c = 0; c < CHANS; c++) begin
                seed = xs(seed);
                idx = (n == 1) ? PILOT_INDEX : (seed[3:0] & 4'he);
                if (n >= SYM - 2) idx = keep[c] ? 4'hf : 4'h0;
                d[12*c +: 12] = seed[27:16];
                s[4*c +: 4] = idx;
                kind = (dc[c] || (dct[c] && n >= SYM - 4)) ? 2'd2 : {1'b0, zero[c]};
                if (on && !bypass_in) expq[c].push_back({kind, n == 0, idx == PILOT_INDEX, idx, d[12*c +: 12]});
            end
            if (bypass_in) begin
                d = {seed, seed[3:0] ^ 4'h5};
                s[11:4] = 8'h00;
                if (on) wq.push_back(d);
            end
            send_word(d, s);
        end
    endtask

    // stop feeding, wait until every expected sample has come out
    task automatic drain();
        word_valid_in = 1'b0;
        for (int k = 0; k < 4000 && expq[0].size() + expq[1].size() + expq[2].size() + wq.size() > 0; k++)
            @(negedge clock_in);
        check(expq[0].size() + expq[1].size() + expq[2].size() + wq.size(), 0);
        watching = 1'b0;
    endtask

    // score each sample handed out; falling edge, where outputs are settled
    always @(negedge clock_in) begin
        if (watching) begin
            for (int c = 0; c < CHANS; c++) begin
                if (sample_valid_out[c] === 1'b1 && expq[c].size() == 0) begin
                    check(36'h1, 36'h0);
                end else if (sample_valid_out[c] === 1'b1) begin
                    e = expq[c].pop_front();
                    got = {symbol_start_out[c], pilot_out[c], sample_index_out[c],
                           sample_i_out[c], sample_q_out[c]};
                    if (e[19:18] == 2'd1) begin
                        check(got[16:0], 17'h0);
                    end else if (e[19:18] == 2'd0 && e[16]) begin
                        check({got[17:12], got[5:0]}, {e[17:12], 6'h00});
                        check(got[11:6] == PILOT_POS || got[11:6] == PILOT_NEG, 1'b1);
                    end else if (e[19:18] == 2'd0) begin
                        check(got, e[17:0]);
                    end
                end
            end
            if (wide_valid_out === 1'b1 && wq.size() == 0) begin
                check(36'h1, 36'h0);
            end else if (wide_valid_out === 1'b1) begin
                check({wide_i_out, wide_q_out}, wq.pop_front());
            end
        end
    end

    // 200 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end

    // hang guard, well beyond the expected run of about 17 us
    initial begin
        #80us;
        failures = failures + 1;
        wrap_up();
    end

    initial begin
        failures = 0;
        checks_done = 0;
        seed = 32'd88362;
        watching = 1'b0;
        reset_in = 1'b1;
        bypass_in = 1'b0;
        word_valid_in = 1'b0;
        word_data_in = '0;
        word_sync_in = '0;
        mute_in = 3'b000;
        repeat (2) @(posedge clock_in);
        @(negedge clock_in);
        reset_in = 1'b0;
        watching = 1'b1;
        // first period only gives the boundary
        send_period(3'b111, 3'b000, 3'b000, 3'b000, 1'b0);
        send_period(3'b111, 3'b000, 3'b000, 3'b000, 1'b1);
        send_period(3'b111, 3'b000, 3'b000, 3'b000, 1'b1);
        check(locked_out, 3'b111);
        $display("test three channels done");
        // channel one loses its prefix, others carry on
        send_period(3'b101, 3'b000, 3'b000, 3'b000, 1'b1);
        send_period(3'b111, 3'b010, 3'b000, 3'b000, 1'b1);
        send_period(3'b111, 3'b000, 3'b000, 3'b000, 1'b1);
        check(locked_out, 3'b111);
        $display("test missing sync done");
        // mute bit on channel two; samples in flight at each change not scored
        send_period(3'b111, 3'b000, 3'b100, 3'b000, 1'b1);
        mute_in = 3'b100;
        send_period(3'b111, 3'b100, 3'b000, 3'b100, 1'b1);
        mute_in = 3'b000;
        send_period(3'b111, 3'b000, 3'b000, 3'b000, 1'b1);
        drain();
        $display("test mute bit done");
        // wide mode, entered under a second reset
        reset_in = 1'b1;
        bypass_in = 1'b1;
        repeat (2) @(negedge clock_in);
        reset_in = 1'b0;
        watching = 1'b1;
        send_period(3'b001, 3'b000, 3'b000, 3'b000, 1'b0);
        send_period(3'b001, 3'b000, 3'b000, 3'b000, 1'b1);
        send_period(3'b001, 3'b000, 3'b000, 3'b000, 1'b1);
        drain();
        repeat (200) @(negedge clock_in);
        $display("test wide mode done");
        wrap_up();
    end
endmodule

`default_nettype wire
